// [lslu_pkg.sv]
// Constants, opcodes, register map and state types of the shift-left unit
package lslu_pkg;

	// ************************************************************
	// Register map (byte offsets)
	// ************************************************************
	localparam int ADDR_W = 6;
	localparam logic [5:0] OFF_SUM = 6'h00;
	localparam logic [5:0] OFF_PRODUCT = 6'h04;
	localparam logic [5:0] OFF_MULTIPLIER = 6'h08;
	localparam logic [5:0] OFF_LINK = 6'h0c;
	localparam logic [5:0] OFF_PC = 6'h10;
	localparam logic [5:0] OFF_FLAGS = 6'h14;
	localparam logic [5:0] OFF_LOOP = 6'h18;
	localparam logic [5:0] OFF_CMD = 6'h1c;
	localparam logic [5:0] OFF_TARGET = 6'h20;
	localparam logic [5:0] OFF_SP = 6'h24;

	// ************************************************************
	// Flag register bit positions
	// ************************************************************
	localparam int FLAG_C = 0;
	localparam int FLAG_N = 1;
	localparam int FLAG_Z = 2;
	localparam int FLAG_ILLEGAL = 3;
	localparam int FLAG_CODE_MODE = 8;
	localparam int FLAG_BUSY = 16;

	// ************************************************************
	// Bus responses
	// ************************************************************
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// ************************************************************
	// Opcodes and opcode prefixes
	// ************************************************************
	localparam logic [11:0] OPC_ACC_IMM_HI = 12'hff3;
	localparam logic [15:0] OPC_ACC_REG = 16'hff50;
	localparam logic [10:0] OPC_HALF_IMM_HI = 11'h7fc;
	localparam logic [14:0] OPC_HALF_REG_HI = 15'h7fb3;
	localparam logic [11:0] OPC_WIDE_IMM_HI = 12'h56a;
	localparam logic [15:0] OPC_WIDE_REG = 16'h5652;
	localparam logic [15:0] OPC_LINK_RET = 16'h0006;
	localparam logic [15:0] OPC_FAR_RET = 16'h7614;
	localparam logic [15:0] OPC_LINK_CALL = 16'h0076;
	localparam logic [15:0] OPC_FAR_CALL = 16'h0074;

	// ************************************************************
	// Cycle counts
	// ************************************************************
	localparam logic [3:0] CYC_LINK_CALL = 4'h4;
	localparam logic [3:0] CYC_LINK_RET = 4'h4;
	localparam logic [3:0] CYC_FAR_CALL = 4'h4;
	localparam logic [3:0] CYC_FAR_RET = 4'h8;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [1:0] {
		LSLU_W16 = 2'b00,
		LSLU_W32 = 2'b01,
		LSLU_W64 = 2'b10
	} lslu_width_type;

	typedef enum logic [3:0] {
		OP_NONE = 4'b0000,
		OP_ACC_IMM = 4'b0001,
		OP_ACC_REG = 4'b0010,
		OP_HALF_IMM = 4'b0011,
		OP_HALF_REG = 4'b0100,
		OP_WIDE_IMM = 4'b0101,
		OP_WIDE_REG = 4'b0110,
		OP_LINK_CALL = 4'b0111,
		OP_LINK_RET = 4'b1000,
		OP_FAR_CALL = 4'b1001,
		OP_FAR_RET = 4'b1010
	} lslu_op_type;

	typedef struct packed {
		logic [31:0] acc;
		logic [31:0] p;
		logic [31:0] mult;
		logic [21:0] link;
		logic [21:0] pc;
		logic [21:0] target;
		logic [3:0] sp;
		logic [15:0][15:0] stack;
		logic c;
		logic n;
		logic z;
		logic illegal;
		logic code_mode;
		logic [15:0] loop_counter;
		logic armed;
		logic rep_active;
		logic [6:0] rep_amt;
		logic [3:0] busy_cnt;
		logic aw_have;
		logic w_have;
		logic [5:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} lslu_state_type;

	localparam lslu_state_type STATE_RESET = lslu_state_type'(0);

endpackage : lslu_pkg

// [lslu_shifter.sv]
// Zero-filling left shifter for 16, 32 and 64 bit operands with carry out
`timescale 1ns/100ps
module lslu_shifter (
	input wire logic [63:0] data_in,
	input wire logic [6:0] amount,
	input wire lslu_pkg::lslu_width_type width,
	output logic [63:0] data_out,
	output logic carry_out
);

	logic [64:0] wide;

	// Operand arrives zero-extended, so the bit just above the width is
	// the last bit out; a zero amount leaves it zero and clears the carry
	always_comb
	begin
		wide = {1'b0, data_in} << amount;
		case (width)
			lslu_pkg::LSLU_W16:
			begin
				data_out = {48'h0, wide[15:0]};
				carry_out = wide[16];
			end
			lslu_pkg::LSLU_W32:
			begin
				data_out = {32'h0, wide[31:0]};
				carry_out = wide[32];
			end
			default:
			begin
				data_out = wide[63:0];
				carry_out = wide[64];
			end
		endcase
	end

endmodule : lslu_shifter

// [lslu_unit.sv]
// Shift-left execution unit with link-register call and return, AXI4-Lite
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
// Operation
// - Immediate accumulator shift: left 1..16, zero fill, last bit out to carry.
// - Accumulator shifts set sign from bit 31, zero from whole accumulator.
// - Immediate accumulator shift repeats count plus one times; flags from final result.
// - Register accumulator shift count is upper operand bits 3..0, rest ignored.
// - Register accumulator shift: zero count clears carry, else last bit out.
// - Zero-count register accumulator shift still updates sign and zero flags.
// - Upper operand is the top 16 bits of the multiplier register.
// - Immediate half shift: selected half left 1..16, zero fill, carry.
// - Half shifts set sign from bit 15, zero when half is zero.
// - Register half shift uses bits 3..0; zero count clears carry.
// - Zero-count register half shift still updates sign and zero flags.
// - Immediate wide shift treats accumulator:product as one 64-bit value.
// - Wide shift sign from accumulator bit 31, zero over all 64 bits.
// - Register wide shift takes its count from upper operand bits 5..0.
// - Register wide count 0..63; zero count clears carry, else last bit.
// - Other shifts are not repeatable: they clear the loop counter, run once.
// - Link call and return take 4 cycles; far return 8, far call 4.
// - Link and stack calls nest and interchange; each link call pushes the old link.
// - Link return: pc from link, pop high then low word, reload link.
module lslu_unit (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [5:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [5:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// ************************************************************
	// Decode helpers
	// ************************************************************
	function automatic lslu_pkg::lslu_op_type decode(input logic [15:0] op,
		input logic code_mode);
		lslu_pkg::lslu_op_type k;
		k = lslu_pkg::OP_NONE;
		if (op[15:4] == lslu_pkg::OPC_ACC_IMM_HI)
			k = lslu_pkg::OP_ACC_IMM;
		else if (op == lslu_pkg::OPC_ACC_REG)
			k = lslu_pkg::OP_ACC_REG;
		else if (op[15:5] == lslu_pkg::OPC_HALF_IMM_HI)
			k = lslu_pkg::OP_HALF_IMM;
		else if (op[15:1] == lslu_pkg::OPC_HALF_REG_HI)
			k = lslu_pkg::OP_HALF_REG;
		else if (op == lslu_pkg::OPC_FAR_RET)
			k = lslu_pkg::OP_FAR_RET;
		else if (op == lslu_pkg::OPC_FAR_CALL)
			k = lslu_pkg::OP_FAR_CALL;
		// These forms only exist in the newer object code mode
		else if (code_mode && op[15:4] == lslu_pkg::OPC_WIDE_IMM_HI)
			k = lslu_pkg::OP_WIDE_IMM;
		else if (code_mode && op == lslu_pkg::OPC_WIDE_REG)
			k = lslu_pkg::OP_WIDE_REG;
		else if (code_mode && op == lslu_pkg::OPC_LINK_CALL)
			k = lslu_pkg::OP_LINK_CALL;
		else if (code_mode && op == lslu_pkg::OPC_LINK_RET)
			k = lslu_pkg::OP_LINK_RET;
		return k;
	endfunction : decode

	function automatic logic half_high(input lslu_pkg::lslu_op_type k, input logic [15:0] op);
		return (k == lslu_pkg::OP_HALF_IMM) ? op[4] : op[0];
	endfunction : half_high

	function automatic logic [6:0] amount_of(input lslu_pkg::lslu_op_type k,
		input logic [15:0] op, input logic [31:0] mult);
		logic [6:0] a;
		case (k)
			lslu_pkg::OP_ACC_REG, lslu_pkg::OP_HALF_REG:
				a = {3'h0, mult[19:16]};
			lslu_pkg::OP_WIDE_REG:
				a = {1'b0, mult[21:16]};
			default:
				a = {3'h0, op[3:0]} + 7'h1;
		endcase
		return a;
	endfunction : amount_of

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] din,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[8*i +: 8] = din[8*i +: 8];
		return r;
	endfunction : merge

	// ************************************************************
	// State and datapath
	// ************************************************************
	lslu_pkg::lslu_state_type st;
	lslu_pkg::lslu_state_type nx;
	lslu_pkg::lslu_op_type op_kind;
	lslu_pkg::lslu_op_type cmd_kind;
	lslu_pkg::lslu_width_type sh_width;
	logic [63:0] sh_data;
	logic [6:0] sh_amt;
	logic [63:0] sh_res;
	logic sh_carry;
	logic busy;
	logic wr_do;
	logic sel_hi;
	logic [15:0] half_val;

	assign busy = (st.busy_cnt != 4'h0) || st.rep_active;
	assign wr_do = st.aw_have && st.w_have;
	assign op_kind = decode(st.wdata[15:0], st.code_mode);
	assign cmd_kind = (wr_do && !busy && st.awaddr == lslu_pkg::OFF_CMD) ? op_kind
		: lslu_pkg::OP_NONE;
	assign sel_hi = half_high(op_kind, st.wdata[15:0]);
	assign half_val = sel_hi ? st.acc[31:16] : st.acc[15:0];
	assign sh_amt = st.rep_active ? st.rep_amt : amount_of(op_kind, st.wdata[15:0], st.mult);
	assign sh_width = (st.rep_active || op_kind == lslu_pkg::OP_ACC_IMM
		|| op_kind == lslu_pkg::OP_ACC_REG) ? lslu_pkg::LSLU_W32
		: (op_kind == lslu_pkg::OP_WIDE_IMM || op_kind == lslu_pkg::OP_WIDE_REG)
		? lslu_pkg::LSLU_W64 : lslu_pkg::LSLU_W16;
	assign sh_data = (sh_width == lslu_pkg::LSLU_W64) ? {st.acc, st.p}
		: (sh_width == lslu_pkg::LSLU_W32) ? {32'h0, st.acc} : {48'h0, half_val};

	lslu_shifter shifter (
		.data_in(sh_data),
		.amount(sh_amt),
		.width(sh_width),
		.data_out(sh_res),
		.carry_out(sh_carry)
	);

	assign s_axi_awready = !st.aw_have && !st.bvalid;
	assign s_axi_wready = !st.w_have && !st.bvalid;
	assign s_axi_arready = !st.rvalid;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rresp = st.rresp;
	assign s_axi_rdata = st.rdata;

	always_comb
	begin
		logic [3:0] sp_up;
		logic [3:0] sp_dn1;
		logic [3:0] sp_dn2;
		logic [21:0] popped;
		logic [21:0] ret_addr;
		sp_up = st.sp + 4'h1;
		sp_dn1 = st.sp - 4'h1;
		sp_dn2 = st.sp - 4'h2;
		popped = {st.stack[sp_dn1][5:0], st.stack[sp_dn2]};
		ret_addr = st.pc + 22'h2;
		nx = st;

		// ************************************************************
		// Bus channels
		// ************************************************************
		if (s_axi_awvalid && s_axi_awready)
		begin
			nx.aw_have = 1'b1;
			nx.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			nx.w_have = 1'b1;
			nx.wdata = s_axi_wdata;
			nx.wstrb = s_axi_wstrb;
		end
		if (st.bvalid && s_axi_bready)
			nx.bvalid = 1'b0;
		if (st.rvalid && s_axi_rready)
			nx.rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			nx.rvalid = 1'b1;
			nx.rresp = lslu_pkg::RESP_OKAY;
			case (s_axi_araddr)
				lslu_pkg::OFF_SUM: nx.rdata = st.acc;
				lslu_pkg::OFF_PRODUCT: nx.rdata = st.p;
				lslu_pkg::OFF_MULTIPLIER: nx.rdata = st.mult;
				lslu_pkg::OFF_LINK: nx.rdata = {10'h0, st.link};
				lslu_pkg::OFF_PC: nx.rdata = {10'h0, st.pc};
				lslu_pkg::OFF_LOOP: nx.rdata = {16'h0, st.loop_counter};
				lslu_pkg::OFF_TARGET: nx.rdata = {10'h0, st.target};
				lslu_pkg::OFF_SP: nx.rdata = {28'h0, st.sp};
				lslu_pkg::OFF_CMD: nx.rdata = 32'h0;
				lslu_pkg::OFF_FLAGS:
				begin
					nx.rdata = 32'h0;
					nx.rdata[lslu_pkg::FLAG_C] = st.c;
					nx.rdata[lslu_pkg::FLAG_N] = st.n;
					nx.rdata[lslu_pkg::FLAG_Z] = st.z;
					nx.rdata[lslu_pkg::FLAG_ILLEGAL] = st.illegal;
					nx.rdata[lslu_pkg::FLAG_CODE_MODE] = st.code_mode;
					nx.rdata[lslu_pkg::FLAG_BUSY] = busy;
				end
				default:
				begin
					nx.rdata = 32'h0;
					nx.rresp = lslu_pkg::RESP_DECERR;
				end
			endcase
		end

		// ************************************************************
		// Multi-cycle timing and repeated shift
		// ************************************************************
		if (st.busy_cnt != 4'h0)
			nx.busy_cnt = st.busy_cnt - 4'h1;
		if (st.rep_active)
		begin
			nx.acc = sh_res[31:0];
			nx.c = sh_carry;
			nx.n = sh_res[31];
			nx.z = (sh_res[31:0] == 32'h0);
			nx.loop_counter = st.loop_counter - 16'h1;
			if (st.loop_counter == 16'h1)
				nx.rep_active = 1'b0;
		end

		// ************************************************************
		// Register writes and command issue
		// ************************************************************
		if (wr_do)
		begin
			nx.aw_have = 1'b0;
			nx.w_have = 1'b0;
			nx.bvalid = 1'b1;
			nx.bresp = lslu_pkg::RESP_OKAY;
			// Changing operands under a running operation would corrupt it
			if (busy)
				nx.bresp = lslu_pkg::RESP_SLVERR;
			else
				case (st.awaddr)
					lslu_pkg::OFF_SUM: nx.acc = merge(st.acc, st.wdata, st.wstrb);
					lslu_pkg::OFF_PRODUCT: nx.p = merge(st.p, st.wdata, st.wstrb);
					lslu_pkg::OFF_MULTIPLIER: nx.mult = merge(st.mult, st.wdata, st.wstrb);
					lslu_pkg::OFF_LINK: nx.link = st.wdata[21:0];
					lslu_pkg::OFF_PC: nx.pc = st.wdata[21:0];
					lslu_pkg::OFF_TARGET: nx.target = st.wdata[21:0];
					lslu_pkg::OFF_SP: nx.sp = st.wdata[3:0];
					lslu_pkg::OFF_LOOP:
					begin
						nx.loop_counter = st.wdata[15:0];
						nx.armed = 1'b1;
					end
					lslu_pkg::OFF_FLAGS:
					begin
						nx.c = st.wdata[lslu_pkg::FLAG_C];
						nx.n = st.wdata[lslu_pkg::FLAG_N];
						nx.z = st.wdata[lslu_pkg::FLAG_Z];
						nx.code_mode = st.wdata[lslu_pkg::FLAG_CODE_MODE];
						if (st.wdata[lslu_pkg::FLAG_ILLEGAL])
							nx.illegal = 1'b0;
					end
					lslu_pkg::OFF_CMD:
					begin
						if (op_kind == lslu_pkg::OP_NONE)
							nx.illegal = 1'b1;
						else if (op_kind == lslu_pkg::OP_ACC_IMM)
						begin
							nx.armed = 1'b0;
							if (st.armed && st.loop_counter != 16'h0)
							begin
								nx.rep_active = 1'b1;
								nx.rep_amt = sh_amt;
							end
						end
						else if (st.armed)
						begin
							nx.armed = 1'b0;
							nx.loop_counter = 16'h0;
						end
						case (op_kind)
							lslu_pkg::OP_ACC_IMM, lslu_pkg::OP_ACC_REG:
							begin
								nx.acc = sh_res[31:0];
								nx.c = sh_carry;
								nx.n = sh_res[31];
								nx.z = (sh_res[31:0] == 32'h0);
							end
							lslu_pkg::OP_HALF_IMM, lslu_pkg::OP_HALF_REG:
							begin
								if (sel_hi)
									nx.acc[31:16] = sh_res[15:0];
								else
									nx.acc[15:0] = sh_res[15:0];
								nx.c = sh_carry;
								nx.n = sh_res[15];
								nx.z = (sh_res[15:0] == 16'h0);
							end
							lslu_pkg::OP_WIDE_IMM, lslu_pkg::OP_WIDE_REG:
							begin
								nx.acc = sh_res[63:32];
								nx.p = sh_res[31:0];
								nx.c = sh_carry;
								nx.n = sh_res[63];
								nx.z = (sh_res == 64'h0);
							end
							lslu_pkg::OP_LINK_CALL:
							begin
								nx.stack[st.sp] = st.link[15:0];
								nx.stack[sp_up] = {10'h0, st.link[21:16]};
								nx.sp = st.sp + 4'h2;
								nx.link = st.pc + 22'h2;
								nx.pc = st.target;
								nx.busy_cnt = lslu_pkg::CYC_LINK_CALL - 4'h1;
							end
							lslu_pkg::OP_LINK_RET:
							begin
								nx.pc = st.link;
								nx.link = popped;
								nx.sp = sp_dn2;
								nx.busy_cnt = lslu_pkg::CYC_LINK_RET - 4'h1;
							end
							lslu_pkg::OP_FAR_CALL:
							begin
								nx.stack[st.sp] = ret_addr[15:0];
								nx.stack[sp_up] = {10'h0, ret_addr[21:16]};
								nx.sp = st.sp + 4'h2;
								nx.pc = st.target;
								nx.busy_cnt = lslu_pkg::CYC_FAR_CALL - 4'h1;
							end
							lslu_pkg::OP_FAR_RET:
							begin
								nx.pc = popped;
								nx.sp = sp_dn2;
								nx.busy_cnt = lslu_pkg::CYC_FAR_RET - 4'h1;
							end
							default:
							begin
							end
						endcase
					end
					default: nx.bresp = lslu_pkg::RESP_DECERR;
				endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st <= lslu_pkg::STATE_RESET;
		else
			st <= nx;
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	acc_imm_shift_a: assert property (cmd_kind == lslu_pkg::OP_ACC_IMM |=>
		st.acc == ($past(st.acc) << ({28'h0, $past(st.wdata[3:0])} + 32'h1)))
		else $error("immediate accumulator shift result wrong");
	acc_flags_a: assert property ((cmd_kind == lslu_pkg::OP_ACC_IMM
		|| cmd_kind == lslu_pkg::OP_ACC_REG) |=> st.n == st.acc[31]
		&& st.z == (st.acc == 32'h0))
		else $error("accumulator sign or zero flag wrong");
	repeat_length_a: assert property (cmd_kind == lslu_pkg::OP_ACC_IMM
		&& st.armed && st.loop_counter == 16'h2 |=> st.rep_active [*2] ##1 !st.rep_active)
		else $error("repeated shift ran wrong number of times");
	reg_count_a: assert property (cmd_kind == lslu_pkg::OP_ACC_REG |=>
		st.acc == ($past(st.acc) << $past(st.mult[19:16])))
		else $error("register count shift used wrong amount");
	zero_count_carry_a: assert property (cmd_kind == lslu_pkg::OP_ACC_REG
		&& st.mult[19:16] == 4'h0 |=> !st.c && st.acc == $past(st.acc))
		else $error("zero count did not clear carry");
	half_flags_a: assert property ((cmd_kind == lslu_pkg::OP_HALF_IMM
		|| cmd_kind == lslu_pkg::OP_HALF_REG) |=> st.n == ($past(sel_hi) ? st.acc[31]
		: st.acc[15]))
		else $error("half shift sign flag wrong");
	wide_flags_a: assert property ((cmd_kind == lslu_pkg::OP_WIDE_IMM
		|| cmd_kind == lslu_pkg::OP_WIDE_REG) |=> st.z == ({st.acc, st.p} == 64'h0)
		&& st.n == st.acc[31])
		else $error("wide shift flags wrong");
	wide_zero_carry_a: assert property (cmd_kind == lslu_pkg::OP_WIDE_REG
		&& st.mult[21:16] == 6'h0 |=> !st.c)
		else $error("wide zero count did not clear carry");
	non_repeat_a: assert property (cmd_kind != lslu_pkg::OP_NONE
		&& cmd_kind != lslu_pkg::OP_ACC_IMM && st.armed |=> !st.armed
		&& st.loop_counter == 16'h0 && !st.rep_active)
		else $error("non-repeatable op did not clear loop counter");
	call_cycles_a: assert property ((cmd_kind == lslu_pkg::OP_LINK_CALL
		|| cmd_kind == lslu_pkg::OP_LINK_RET) |=> busy [*3] ##1 !busy)
		else $error("link call or return not four cycles");
	far_return_cycles_a: assert property (cmd_kind == lslu_pkg::OP_FAR_RET
		|=> busy [*7] ##1 !busy)
		else $error("far return not eight cycles");
	link_return_a: assert property (cmd_kind == lslu_pkg::OP_LINK_RET |=>
		st.pc == $past(st.link) && st.sp == $past(st.sp) - 4'h2)
		else $error("link return did not restore pc");

endmodule : lslu_unit

// [lslu_unit_test.sv]
// Self-checking testbench of the shift-left unit, driven over its register bus
`timescale 1ns/100ps
module lslu_unit_test;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [5:0] awaddr = 6'h00;
	logic [5:0] araddr = 6'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, rr;
	logic [31:0] rdata, r;
	int mismatches = 0;
	int n_compared = 0;

	always #25 aclk = ~aclk;

	lslu_unit dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

	// ****************
	// Bus and compare tasks
	// ****************
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		bit ad;
		bit wd;
		ad = 1'b0;
		wd = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ad && wd))
		begin
			@(posedge aclk);
			ad = ad || awready;
			wd = wd || wready;
			if (ad)
				awvalid <= 1'b0;
			if (wd)
				wvalid <= 1'b0;
		end
		// Response cannot stand before the edge after the one that took the last channel
		while (!bvalid)
			@(posedge aclk);
		chk("write resp", {30'h0, lslu_pkg::RESP_OKAY}, {30'h0, bresp});
		bready <= 1'b0;
		@(posedge aclk);
	endtask : wr

	task automatic rd(input logic [5:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		@(posedge aclk);
		while (!arready)
			@(posedge aclk);
		arvalid <= 1'b0;
		while (!rvalid)
			@(posedge aclk);
		r = rdata;
		rr = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask : rd

	task automatic op(input logic [15:0] o);
		wr(lslu_pkg::OFF_CMD, {16'h0, o});
		do
			rd(lslu_pkg::OFF_FLAGS);
		while (r[lslu_pkg::FLAG_BUSY]);
	endtask : op

	task automatic chk_reg(input logic [5:0] a, input logic [31:0] e);
		rd(a);
		chk($sformatf("reg %h", a), e, r);
	endtask : chk_reg

	task automatic flags(input logic [2:0] zero_msb_carry);
		rd(lslu_pkg::OFF_FLAGS);
		chk("flags", {29'h0, zero_msb_carry}, {29'h0, r[2:0]});
	endtask : flags

	// ****************
	// Scenarios
	// ****************
	task automatic t_reset();
		chk_reg(lslu_pkg::OFF_FLAGS, 32'h0);
		// Link call is refused until the code mode bit is set
		wr(lslu_pkg::OFF_CMD, 32'h0000_0076);
		chk_reg(lslu_pkg::OFF_FLAGS, 32'h1 << lslu_pkg::FLAG_ILLEGAL);
		chk_reg(lslu_pkg::OFF_PC, 32'h0);
		wr(lslu_pkg::OFF_FLAGS, 32'h1 << lslu_pkg::FLAG_ILLEGAL);
		chk_reg(lslu_pkg::OFF_FLAGS, 32'h0);
		rd(6'h28);
		chk("unmapped resp", {30'h0, lslu_pkg::RESP_DECERR}, {30'h0, rr});
	endtask : t_reset

	task automatic t_acc_imm();
		wr(lslu_pkg::OFF_SUM, 32'h8000_0001);
		op(16'hff30);
		chk_reg(lslu_pkg::OFF_SUM, 32'h0000_0002);
		flags(3'b001);
		wr(lslu_pkg::OFF_SUM, 32'h0001_8000);
		op(16'hff3f);
		chk_reg(lslu_pkg::OFF_SUM, 32'h8000_0000);
		flags(3'b011);
		wr(lslu_pkg::OFF_SUM, 32'h6000_0000);
		wr(lslu_pkg::OFF_LOOP, 32'h2);
		op(16'hff30);
		chk_reg(lslu_pkg::OFF_SUM, 32'h0);
		flags(3'b101);
	endtask : t_acc_imm

	task automatic t_acc_reg();
		// Low half of the multiplier holds a decoy count
		wr(lslu_pkg::OFF_MULTIPLIER, 32'hfff4_000b);
		wr(lslu_pkg::OFF_SUM, 32'h1800_0001);
		op(16'hff50);
		chk_reg(lslu_pkg::OFF_SUM, 32'h8000_0010);
		flags(3'b011);
		wr(lslu_pkg::OFF_MULTIPLIER, 32'h0010_0003);
		op(16'hff50);
		flags(3'b010);
	endtask : t_acc_reg

	task automatic t_half();
		wr(lslu_pkg::OFF_SUM, 32'h4000_8001);
		op(16'hff91);
		chk_reg(lslu_pkg::OFF_SUM, 32'h0000_8001);
		flags(3'b101);
		wr(lslu_pkg::OFF_MULTIPLIER, 32'h0001_0000);
		op(16'hff66);
		chk_reg(lslu_pkg::OFF_SUM, 32'h0000_0002);
		flags(3'b001);
		wr(lslu_pkg::OFF_SUM, 32'h8000_0000);
		wr(lslu_pkg::OFF_MULTIPLIER, 32'h0);
		op(16'hff67);
		flags(3'b010);
	endtask : t_half

	task automatic t_wide();
		wr(lslu_pkg::OFF_FLAGS, 32'h0000_0100);
		wr(lslu_pkg::OFF_SUM, 32'h1);
		wr(lslu_pkg::OFF_PRODUCT, 32'h8000_0000);
		op(16'h56a0);
		chk_reg(lslu_pkg::OFF_SUM, 32'h3);
		chk_reg(lslu_pkg::OFF_PRODUCT, 32'h0);
		flags(3'b000);
		// Bit 6 of the count must be ignored
		wr(lslu_pkg::OFF_MULTIPLIER, 32'h0060_0000);
		wr(lslu_pkg::OFF_PRODUCT, 32'h5);
		op(16'h5652);
		chk_reg(lslu_pkg::OFF_SUM, 32'h5);
		flags(3'b001);
		// Zero count with bit 6 set: no shift, carry cleared
		wr(lslu_pkg::OFF_MULTIPLIER, 32'h0040_0000);
		op(16'h5652);
		chk_reg(lslu_pkg::OFF_SUM, 32'h5);
		flags(3'b000);
	endtask : t_wide

	task automatic t_once();
		wr(lslu_pkg::OFF_LOOP, 32'h3);
		wr(lslu_pkg::OFF_MULTIPLIER, 32'h0001_0000);
		wr(lslu_pkg::OFF_SUM, 32'h1);
		op(16'hff50);
		chk_reg(lslu_pkg::OFF_SUM, 32'h2);
		chk_reg(lslu_pkg::OFF_LOOP, 32'h0);
	endtask : t_once

	task automatic t_calls();
		wr(lslu_pkg::OFF_PC, 32'h40);
		wr(lslu_pkg::OFF_LINK, 32'h1234);
		wr(lslu_pkg::OFF_TARGET, 32'h100);
		op(16'h0076);
		chk_reg(lslu_pkg::OFF_PC, 32'h100);
		chk_reg(lslu_pkg::OFF_LINK, 32'h42);
		op(16'h0006);
		chk_reg(lslu_pkg::OFF_PC, 32'h42);
		chk_reg(lslu_pkg::OFF_LINK, 32'h1234);
		wr(lslu_pkg::OFF_TARGET, 32'h200);
		op(16'h0074);
		chk_reg(lslu_pkg::OFF_PC, 32'h200);
		op(16'h7614);
		chk_reg(lslu_pkg::OFF_PC, 32'h44);
	endtask : t_calls

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done

	initial
	begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		t_acc_imm();
		t_acc_reg();
		t_half();
		t_wide();
		t_once();
		t_calls();
		test_done();
	end

	// Tests need a few hundred cycles; allow far more before declaring a hang
	initial
	begin
		#2000000;
		mismatches++;
		test_done();
	end
endmodule : lslu_unit_test
